/* File: design/ssf_defs.vh */
`ifndef SSF_DEFS_VH
`define SSF_DEFS_VH

// register map of the buffer block
`define SSF_ADDR_LIVE_HI 8'h01
`define SSF_ADDR_LIVE_LAST 8'h05
`define SSF_ADDR_IDENT 8'h0c
`define SSF_ADDR_STATUS 8'h0d
`define SSF_ADDR_DATA 8'h0e
`define SSF_ADDR_CONFIG 8'h0f
`define SSF_ADDR_TICKS 8'h10

// mode field codes
`define SSF_MODE_OFF 2'h0
`define SSF_MODE_CIRC 2'h1
`define SSF_MODE_STOP 2'h2

// config field positions
`define SSF_CFG_MODE_HI 7
`define SSF_CFG_MODE_LO 6
`define SSF_CFG_MARK_HI 5
`define SSF_CFG_MARK_LO 0

// sample geometry
`define SSF_SAMPLE_W 40
`define SSF_DEPTH 32
`define SSF_PTR_W 5
`define SSF_CNT_W 6
`define SSF_CNT_FULL 6'h20
`define SSF_CNT_ZERO 6'h00
`define SSF_CNT_ONE 6'h01
`define SSF_PTR_ONE 5'h01
`define SSF_LAST_BYTE 3'h4
`define SSF_IDX_ZERO 3'h0
`define SSF_IDX_ONE 3'h1
`define SSF_TICK_MAX 8'hff
`define SSF_TICK_ONE 8'h01

// input staging buffer
`define SSF_STAGE_DEPTH 4
`define SSF_STAGE_AW 2

// neutral identifier held from reset until the storage value is caught; value is arbitrary
`define SSF_ID_DEFAULT 8'h5a

`endif

/* File: design/ssf_sample_mem.v */
`default_nettype none

// sample store; read data comes out of a register one cycle after the address
module ssf_sample_mem #(
   parameter WIDTH = 40,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire clk,
   input wire resetn,
   input wire ce,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [WIDTH-1:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [WIDTH-1:0] rdata_q
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];

   // array has no reset; only the output register is cleared
   always @(posedge clk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end

   // read is registered; a word written on the same edge is forwarded, so a sample
   // stored into an empty buffer can be read on the very next cycle
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= {WIDTH{1'b0}};
      end else if (ce) begin
         if (we && waddr == raddr) begin
            rdata_q <= wdata;
         end else begin
            rdata_q <= mem[raddr];
         end
      end
   end
endmodule // ssf_sample_mem

`default_nettype wire

/* File: design/ssf_stage_fifo.v */
`default_nettype none

// small valid/ready staging queue in front of the sample store
module ssf_stage_fifo #(
   parameter WIDTH = 40,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire clk,
   input wire resetn,
   input wire ce,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire [WIDTH-1:0] slot [0:DEPTH-1];
   wire push;
   wire pop;

   // honest full and empty from the occupancy count
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign push = in_valid && in_ready && ce;
   assign pop = out_valid && out_ready && ce;
   assign out_data = slot[rd_q];

   // one storage register per slot
   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : g_slot
         reg [WIDTH-1:0] data_q;
         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               data_q <= {WIDTH{1'b0}};
            end else if (push && wr_q == g[AW-1:0]) begin
               data_q <= in_data;
            end
         end
         assign slot[g] = data_q;
      end
   endgenerate

   // pointers wrap naturally since depth is a power of two
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
         end else if (pop && !push) begin
            cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // ssf_stage_fifo

`default_nettype wire

/* File: design/ssf_sample_buffer.v */
`include "ssf_defs.vh"
`default_nettype none

module ssf_sample_buffer (
   input wire clk,
   input wire resetn,
   input wire ce,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   input wire reg_rd,
   output reg [7:0] reg_rdata_q,
   input wire [7:0] nvm_id,
   input wire system_active,
   input wire sample_tick,
   input wire sample_valid,
   output wire sample_ready,
   input wire [39:0] sample_data,
   output reg buffer_event_source_q,
   output reg overflow_flag_q,
   output reg level_mark_flag_q,
   output reg [5:0] sample_count_q
);
   // configuration, pointers and byte index of the sample under read
   reg [1:0] mode_q;
   reg [1:0] mode_d;
   reg [5:0] level_mark_q;
   reg [5:0] level_mark_d;
   reg [4:0] head_q;
   reg [4:0] head_d;
   reg [4:0] tail_q;
   reg [4:0] tail_d;
   reg [5:0] count_d;
   reg [2:0] idx_q;
   reg [2:0] idx_d;
   reg overflow_d;
   reg level_mark_flag_d;
   reg event_d;
   reg [7:0] tick_value_q;
   reg [7:0] tick_value_d;
   reg active_q;
   reg [7:0] device_identifier_q;
   reg id_taken_q;
   reg [7:0] rdata_d;
   reg mem_we;
   reg flush;
   reg emptied;
   // decoded strobes and the datapath between queue, store and read mux
   wire enabled;
   wire cfg_wr;
   wire status_rd;
   wire data_rd;
   wire stage_valid;
   wire [39:0] stage_data;
   wire [39:0] mem_rdata;
   wire drain;
   wire ovf_rise;
   wire mark_rise;

   // data port address decode, used by read mux and pop logic
   function is_data_addr;
      input [7:0] a;
      begin
         is_data_addr = (a == `SSF_ADDR_DATA) || (a == `SSF_ADDR_LIVE_HI);
      end
   endfunction

   // byte order of one stored sample
   // index zero is the pressure high byte, four the temperature low byte
   function [7:0] byte_of;
      input [39:0] s;
      input [2:0] i;
      begin
         case (i)
            3'h0: byte_of = s[39:32];
            3'h1: byte_of = s[31:24];
            3'h2: byte_of = s[23:16];
            3'h3: byte_of = s[15:8];
            default: byte_of = s[7:0];
         endcase
      end
   endfunction

   assign enabled = (mode_q == `SSF_MODE_CIRC) || (mode_q == `SSF_MODE_STOP);
   assign cfg_wr = ce && reg_wr && (reg_addr == `SSF_ADDR_CONFIG);
   assign status_rd = ce && reg_rd && (reg_addr == `SSF_ADDR_STATUS);
   assign data_rd = ce && reg_rd && enabled && is_data_addr(reg_addr);
   // the store has one port per cycle for pops, so staging stalls during a data read;
   // the staging queue keeps samples arriving meanwhile
   assign drain = stage_valid && !data_rd;

   // samples enter through a 4-word staging queue; its ready is the source back-pressure
   // a data burst longer than four sample periods holds the source off; the queue drops nothing, but samples drained while off or full in stop mode are discarded
   ssf_stage_fifo #(
      .WIDTH(`SSF_SAMPLE_W),
      .DEPTH(`SSF_STAGE_DEPTH),
      .AW(`SSF_STAGE_AW)
   ) u_stage (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data(sample_data),
      .out_valid(stage_valid),
      .out_ready(drain),
      .out_data(stage_data)
   );

   // sample store; read address follows the next head so oldest data is ready
   ssf_sample_mem #(
      .WIDTH(`SSF_SAMPLE_W),
      .DEPTH(`SSF_DEPTH),
      .AW(`SSF_PTR_W)
   ) u_mem (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .we(mem_we),
      .waddr(tail_q),
      .wdata(stage_data),
      .raddr(head_d),
      .rdata_q(mem_rdata)
   );

   // next state of mode, pointers and count
   // a read and a drain never share a cycle, so the store needs only one port
   always @* begin
      mode_d = mode_q;
      level_mark_d = level_mark_q;
      head_d = head_q;
      tail_d = tail_q;
      count_d = sample_count_q;
      idx_d = idx_q;
      mem_we = 1'b0;
      emptied = 1'b0;
      if (cfg_wr) begin
         mode_d = reg_wdata[`SSF_CFG_MODE_HI:`SSF_CFG_MODE_LO];
         level_mark_d = reg_wdata[`SSF_CFG_MARK_HI:`SSF_CFG_MARK_LO];
      end
      // off mode, a write of off, or standby to active all empty the store
      // active_q is frozen with ce, so an edge seen while ce is low is acted on later
      flush = (mode_d == `SSF_MODE_OFF) || (ce && system_active && !active_q);
      if (flush) begin
         head_d = {`SSF_PTR_W{1'b0}};
         tail_d = {`SSF_PTR_W{1'b0}};
         count_d = `SSF_CNT_ZERO;
         idx_d = `SSF_IDX_ZERO;
      end else if (data_rd && sample_count_q != `SSF_CNT_ZERO) begin
         // one byte leaves per read; fifth byte retires the sample
         if (idx_q == `SSF_LAST_BYTE) begin
            idx_d = `SSF_IDX_ZERO;
            head_d = head_q + `SSF_PTR_ONE;
            count_d = sample_count_q - `SSF_CNT_ONE;
            emptied = (sample_count_q == `SSF_CNT_ONE);
         end else begin
            idx_d = idx_q + `SSF_IDX_ONE;
         end
      end else if (ce && drain && enabled) begin
         // one sample per cycle from the staging queue; watermark never blocks
         if (sample_count_q != `SSF_CNT_FULL) begin
            mem_we = 1'b1;
            tail_d = tail_q + `SSF_PTR_ONE;
            count_d = sample_count_q + `SSF_CNT_ONE;
         end else if (mode_q == `SSF_MODE_CIRC) begin
            // overwrite oldest; count stays at full
            // a partly read oldest sample is lost; reads restart at byte one of the next
            mem_we = 1'b1;
            tail_d = tail_q + `SSF_PTR_ONE;
            head_d = head_q + `SSF_PTR_ONE;
            idx_d = `SSF_IDX_ZERO;
         end
      end
   end

   // flag levels follow the next count and mode, so they move on the count's edge
   always @* begin
      overflow_d = (mode_d != `SSF_MODE_OFF) && (count_d == `SSF_CNT_FULL);
      level_mark_flag_d = (mode_d != `SSF_MODE_OFF) && (level_mark_d != `SSF_CNT_ZERO)
         && (count_d >= level_mark_d);
   end

   // each flag's own rising edge is an event: an overflow still counts while the level
   // mark is already up, which a single edge on the or of both would miss
   assign ovf_rise = ce && overflow_d && !overflow_flag_q;
   assign mark_rise = ce && level_mark_flag_d && !level_mark_flag_q;

   // a new event wins over a status-read clear in the same cycle, so none is lost
   always @* begin
      event_d = buffer_event_source_q;
      if (status_rd) begin
         event_d = 1'b0;
      end
      if (ovf_rise || mark_rise) begin
         event_d = 1'b1;
      end
   end

   // tick counter runs while overflowed, saturates, clears on emptying read
   // saturating keeps a long overflow from wrapping back to a small, misleading age
   always @* begin
      tick_value_d = tick_value_q;
      if (flush || emptied) begin
         tick_value_d = {8{1'b0}};
      end else if (ce && overflow_flag_q && sample_tick && tick_value_q != `SSF_TICK_MAX) begin
         tick_value_d = tick_value_q + `SSF_TICK_ONE;
      end
   end

   // read data mux; live pressure and temperature bytes sit outside this block,
   // so with the buffer off 01h to 05h read zero
   // a read of an empty enabled buffer still counts as a data read and stalls the drain
   always @* begin
      rdata_d = reg_rdata_q;
      if (ce && reg_rd) begin
         rdata_d = 8'h00;
         if (data_rd) begin
            if (sample_count_q != `SSF_CNT_ZERO) begin
               rdata_d = byte_of(mem_rdata, idx_q);
            end // empty buffer reads zero
         end else begin
            case (reg_addr)
               `SSF_ADDR_IDENT: rdata_d = device_identifier_q;
               `SSF_ADDR_STATUS: rdata_d = {overflow_flag_q, level_mark_flag_q,
                  sample_count_q};
               `SSF_ADDR_CONFIG: rdata_d = {mode_q, level_mark_q};
               `SSF_ADDR_TICKS: rdata_d = tick_value_q;
               default: rdata_d = 8'h00; // 02h-05h read zero while enabled
            endcase
         end
      end
   end

   // identifier is caught from storage once, after reset release
   // later changes on the storage input are ignored, so the value reads the same all run
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         device_identifier_q <= `SSF_ID_DEFAULT;
         id_taken_q <= 1'b0;
      end else if (ce && !id_taken_q) begin
         device_identifier_q <= nvm_id;
         id_taken_q <= 1'b1;
      end
   end

   // state registers, all cleared to off and empty
   // ce low holds these, the staging queue and the store alike
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= `SSF_MODE_OFF;
         level_mark_q <= `SSF_CNT_ZERO;
         head_q <= {`SSF_PTR_W{1'b0}};
         tail_q <= {`SSF_PTR_W{1'b0}};
         sample_count_q <= `SSF_CNT_ZERO;
         idx_q <= `SSF_IDX_ZERO;
         overflow_flag_q <= 1'b0;
         level_mark_flag_q <= 1'b0;
         buffer_event_source_q <= 1'b0;
         tick_value_q <= 8'h00;
         active_q <= 1'b0;
         reg_rdata_q <= 8'h00;
      end else if (ce) begin
         mode_q <= mode_d;
         level_mark_q <= level_mark_d;
         head_q <= head_d;
         tail_q <= tail_d;
         sample_count_q <= count_d;
         idx_q <= idx_d;
         overflow_flag_q <= overflow_d;
         level_mark_flag_q <= level_mark_flag_d;
         buffer_event_source_q <= event_d;
         tick_value_q <= tick_value_d;
         active_q <= system_active;
         reg_rdata_q <= rdata_d;
      end
   end
endmodule // ssf_sample_buffer

`default_nettype wire

/* File: testbench/ssf_sample_buffer_checker.sv */
`default_nettype none

// port-level watch on the buffer block; config is shadowed from register writes
module ssf_sample_buffer_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_q,
   input wire logic [7:0] nvm_id,
   input wire logic system_active,
   input wire logic buffer_event_source_q,
   input wire logic overflow_flag_q,
   input wire logic level_mark_flag_q,
   input wire logic [5:0] sample_count_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cfg_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // shadow of the config register, so flag levels can be predicted
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         cfg_q <= 8'h00;
      else if (ce && reg_wr && reg_addr == 8'h0f)
         cfg_q <= reg_wdata;
   end
   sequence s_rd(a);
      ce && reg_rd && reg_addr == a;
   endsequence
   sequence s_flags_still;
      $stable({overflow_flag_q, level_mark_flag_q});
   endsequence
   a_ovf_tracks_full: assert property (
      overflow_flag_q == (sample_count_q == 6'h20)) else $error("overflow flag off");
   a_mark_level: assert property ($stable(cfg_q) |-> level_mark_flag_q ==
      (cfg_q[5:0] != 6'h00 && sample_count_q >= cfg_q[5:0] && cfg_q[7:6] != 2'h0))
      else $error("level mark flag off");
   a_event_on_rise: assert property (
      $rose(overflow_flag_q) || $rose(level_mark_flag_q) |-> buffer_event_source_q)
      else $error("event bit not set");
   a_event_has_cause: assert property (
      $rose(buffer_event_source_q) |-> overflow_flag_q || level_mark_flag_q)
      else $error("event bit set without cause");
   a_status_clears: assert property (
      s_flags_still ##0 s_rd(8'h0d) ##1 s_flags_still |-> !buffer_event_source_q)
      else $error("status read left event bit");
   a_count_steps: assert property (sample_count_q > $past(sample_count_q) |->
      sample_count_q == $past(sample_count_q) + 6'h01) else $error("count jumped");
   a_ident_read: assert property (
      $past(resetn) ##0 s_rd(8'h0c) |=> reg_rdata_q == nvm_id) else $error("identifier wrong");
   a_live_zero: assert property (cfg_q[7:6] != 2'h0 && ce && reg_rd &&
      reg_addr inside {[8'h02:8'h05]} |=> reg_rdata_q == 8'h00) else $error("live byte not 0");
   a_full_holds: assert property (cfg_q[7:6] != 2'h0 && sample_count_q == 6'h20 &&
      !reg_rd && !reg_wr && system_active && $past(system_active) |=> sample_count_q == 6'h20)
      else $error("full count lost");
endmodule // ssf_sample_buffer_checker

bind ssf_sample_buffer ssf_sample_buffer_checker u_chk (
   .clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .nvm_id(nvm_id),
   .system_active(system_active), .buffer_event_source_q(buffer_event_source_q),
   .overflow_flag_q(overflow_flag_q), .level_mark_flag_q(level_mark_flag_q),
   .sample_count_q(sample_count_q)
);

`default_nettype wire

/* File: testbench/ssf_host_model.sv */
`default_nettype none

// host side of the register port: single writes and burst reads
module ssf_host_model (
   input wire logic clk,
   output var logic [7:0] reg_addr,
   output var logic reg_wr,
   output var logic [7:0] reg_wdata,
   output var logic reg_rd,
   input wire logic [7:0] reg_rdata_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got [0:159];
   // idle bus from time zero
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // one byte write; data is scrambled after so nothing leans on a stale value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // strobe stays up one cycle per byte; each byte is picked up a cycle later
   task automatic rd(input logic [7:0] a, input int n);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         got[i] = reg_rdata_q;
      end
      reg_rd = 1'b0;
   endtask
endmodule // ssf_host_model

`default_nettype wire

/* File: testbench/sensor_sample_fifo_test.sv */
`default_nettype none

// bench drives acquisition and system state, the host model the register port
module sensor_sample_fifo_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ID = 8'h3c; // arbitrary value
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic system_active = 1'b1;
   logic sample_tick = 1'b0;
   logic sample_valid = 1'b0;
   logic [39:0] sample_data = 40'h0;
   logic saw_full = 1'b0;
   int num_errors = 0;
   int check_count = 0;
   wire logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
   wire logic reg_wr, reg_rd, sample_ready;
   wire logic buffer_event_source_q, overflow_flag_q, level_mark_flag_q;
   wire logic [5:0] sample_count_q;
   always #2.5 clk = ~clk;
   ssf_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
   ssf_sample_buffer u_dut (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .nvm_id(ID), .system_active(system_active), .sample_tick(sample_tick),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
      .buffer_event_source_q(buffer_event_source_q), .overflow_flag_q(overflow_flag_q),
      .level_mark_flag_q(level_mark_flag_q), .sample_count_q(sample_count_q));
   // note whether the staging queue ever pushed back
   always @(negedge clk) begin
      if (sample_valid && !sample_ready)
         saw_full = 1'b1;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, 1);
      chk(u_host.got[0], e);
   endtask
   function automatic logic [39:0] cat5(input int k);
      return {u_host.got[k], u_host.got[k+1], u_host.got[k+2],
         u_host.got[k+3], u_host.got[k+4]};
   endfunction
   // sample i: bytes 11 22 33 44 then i, so order and age both show
   task automatic push(input int i);
      @(negedge clk);
      sample_data = {32'h11223344, i[7:0]};
      sample_valid = 1'b1;
      while (sample_ready !== 1'b1)
         @(negedge clk);
      @(negedge clk);
      sample_valid = 1'b0;
      sample_data = ~sample_data;
   endtask
   // waits past the store's write and read latency
   task automatic pushn(input int first, input int n);
      for (int i = 0; i < n; i++)
         push(first + i);
      repeat (3) @(negedge clk);
   endtask
   task automatic t_reset;
      rchk(8'h0d, 8'h00);
      rchk(8'h0e, 8'h00);
      rchk(8'h0f, 8'h00);
      rchk(8'h10, 8'h00);
      u_host.wr(8'h0c, 8'h99);
      rchk(8'h0c, ID);
   endtask
   task automatic t_order;
      u_host.wr(8'h0f, 8'h40);
      pushn(0, 3);
      rchk(8'h0d, 8'h03);
      chk({buffer_event_source_q, level_mark_flag_q}, 2'b00);
      u_host.rd(8'h01, 5);
      chk(cat5(0), 40'h1122334400);
      rchk(8'h0d, 8'h02);
      for (int a = 2; a < 6; a++) begin
         rchk(8'(a), 8'h00);
      end
      u_host.rd(8'h0e, 10);
      chk(cat5(5), 40'h1122334402);
      rchk(8'h0e, 8'h00);
      rchk(8'h0d, 8'h00);
   endtask
   task automatic t_mark;
      u_host.wr(8'h0f, 8'h43);
      pushn(0, 2);
      chk({buffer_event_source_q, level_mark_flag_q}, 2'b00);
      pushn(2, 1);
      chk({buffer_event_source_q, level_mark_flag_q}, 2'b11);
      pushn(3, 1);
      rchk(8'h0d, 8'h44);
      chk({buffer_event_source_q, level_mark_flag_q}, 2'b01);
      u_host.wr(8'h0f, 8'h00);
      chk({overflow_flag_q, level_mark_flag_q, sample_count_q}, 8'h00);
   endtask
   task automatic t_stop;
      u_host.wr(8'h0f, 8'h80);
      pushn(0, 34);
      chk(buffer_event_source_q, 1'b1);
      rchk(8'h0d, 8'ha0);
      u_host.rd(8'h0e, 5);
      chk(cat5(0), 40'h1122334400);
      rchk(8'h0d, 8'h1f);
      u_host.wr(8'h0f, 8'h00);
   endtask
   // level mark already up when the overflow comes: the overflow must still raise the event
   task automatic t_circ;
      u_host.wr(8'h0f, 8'h43);
      pushn(0, 4);
      rchk(8'h0d, 8'h44);
      pushn(4, 30);
      chk(buffer_event_source_q, 1'b1);
      repeat (3) begin
         @(negedge clk);
         sample_tick = 1'b1;
         @(negedge clk);
         sample_tick = 1'b0;
      end
      rchk(8'h10, 8'h03);
      rchk(8'h0d, 8'he0);
      u_host.rd(8'h0e, 160);
      chk(cat5(0), 40'h1122334402);
      chk(cat5(155), 40'h1122334421);
      rchk(8'h10, 8'h00);
   endtask
   // reads stall the drain, so the 4-word queue fills and refuses
   task automatic t_fill;
      fork
         u_host.rd(8'h0e, 20);
         pushn(40, 5);
      join
      chk(saw_full, 1'b1);
      rchk(8'h0d, 8'h45);
      u_host.rd(8'h0e, 5);
      chk(cat5(0), 40'h1122334428);
      @(negedge clk);
      system_active = 1'b0;
      @(negedge clk);
      system_active = 1'b1;
      repeat (3) @(negedge clk);
      rchk(8'h0d, 8'h00);
   endtask
   // ce low freezes the block: no sample taken, no byte popped, read port holds
   task automatic t_hold;
      pushn(50, 1);
      rchk(8'h0d, 8'h01);
      @(negedge clk);
      ce = 1'b0;
      push(51);
      u_host.rd(8'h0e, 5);
      chk(u_host.got[4], 8'h01);
      chk(sample_count_q, 6'h01);
      @(negedge clk);
      ce = 1'b1;
      u_host.rd(8'h0e, 5);
      chk(cat5(0), 40'h1122334432);
      rchk(8'h0d, 8'h00);
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      t_reset();
      t_order();
      t_mark();
      t_stop();
      t_circ();
      t_fill();
      t_hold();
      wrap_up();
   end
   // cut a hang short
   initial begin
      #50000;
      num_errors++;
      wrap_up();
   end
endmodule // sensor_sample_fifo_test

`default_nettype wire
